// file: src/tpl_pkg.sv
// Purpose: Shared constants and types for the tone program loader
// Assumes: 100 MHz core clock, 16-bit program words
// Notes:   Table layouts match the header-selected programming sequences
package tpl_pkg;
    // ------------------------------------------------------------
    // Port, headers and word ranges
    // ------------------------------------------------------------
    localparam logic [7:0] PROG_ADDR = 8'he8;
    localparam logic [15:0] HDR_TX = 16'h8000;
    localparam logic [15:0] HDR_RX = 16'h8001;
    localparam logic [15:0] TX_DATA_MAX = 16'h3fff;
    localparam logic [15:0] RX_DATA_MAX = 16'h7fff;
    localparam int TX_WORDS = 16;
    localparam int RX_WORDS = 26;
    localparam int RX_CH_STRIDE = 13;
    localparam int RX_IDX_B0A = 2;
    localparam int RX_IDX_B0B = 7;
    localparam int RX_IDX_NCYC = 10;
    localparam int RX_IDX_MIN = 11;
    localparam int RX_IDX_MAX = 12;
    // ------------------------------------------------------------
    // Status and control bit positions
    // ------------------------------------------------------------
    localparam int ST_TONE1_BIT = 6;
    localparam int ST_TONE2_BIT = 7;
    localparam int ST_BOTH_BIT = 10;
    localparam int ST_PROG_BIT = 13;
    localparam int CTRL_PROG_MASK_BIT = 4;
    localparam logic [15:0] STATUS_RESET = 16'h2000;
    localparam logic [3:0] SINGLE_RESET = 4'h7;
    // ------------------------------------------------------------
    // Timing and scaling
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROC_TIME_NS = 150000;
    localparam int PROC_LIMIT_CYCLES = PROC_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_HZ = 9600;
    localparam int FREQ_X1000 = 3414;
    localparam int TX_FMAX_HZ = 3400;
    localparam logic [15:0] TX_FREQ_MAX = 16'(TX_FMAX_HZ * FREQ_X1000 / 1000);
    // ------------------------------------------------------------
    // Defaults after reset or powersave
    // ------------------------------------------------------------
    localparam int DEF_F1_HZ = 2130;
    localparam int DEF_F2_HZ = 2750;
    localparam logic [15:0] DEF_TX_F1 = 16'(DEF_F1_HZ * FREQ_X1000 / 1000);
    localparam logic [15:0] DEF_TX_F2 = 16'(DEF_F2_HZ * FREQ_X1000 / 1000);
    localparam logic [15:0] DEF_LEVEL = 16'h089a; // About -20 dBm at 3.3 V
    localparam logic [15:0] UNITY_COEF = 16'h2000;
    localparam int DEF_NCYC = 8;
    localparam int DEF_TOL_PCT = 5;
    localparam logic [15:0] DEF_MIN1 =
        16'(TIMER_HZ * DEF_NCYC * 100 / (DEF_F1_HZ * (100 + DEF_TOL_PCT)));
    localparam logic [15:0] DEF_MAX1 =
        16'(TIMER_HZ * DEF_NCYC * 100 / (DEF_F1_HZ * (100 - DEF_TOL_PCT)));
    localparam logic [15:0] DEF_MIN2 =
        16'(TIMER_HZ * DEF_NCYC * 100 / (DEF_F2_HZ * (100 + DEF_TOL_PCT)));
    localparam logic [15:0] DEF_MAX2 =
        16'(TIMER_HZ * DEF_NCYC * 100 / (DEF_F2_HZ * (100 - DEF_TOL_PCT)));

    typedef logic [TX_WORDS-1:0][15:0] tpl_tx_t;
    typedef logic [RX_WORDS-1:0][15:0] tpl_rx_t;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_TX = 2'b01,
        SEQ_RX = 2'b10
    } tpl_seq_e;

    function automatic tpl_tx_t tx_defaults();
        tpl_tx_t t;
        t = '0;
        t[12] = DEF_TX_F1;
        t[13] = DEF_LEVEL;
        t[14] = DEF_TX_F2;
        t[15] = DEF_LEVEL;
        return t;
    endfunction

    function automatic tpl_rx_t rx_defaults();
        tpl_rx_t r;
        r = '0;
        for (int c = 0; c < 2; c++) begin
            r[c*RX_CH_STRIDE+RX_IDX_B0A] = UNITY_COEF;
            r[c*RX_CH_STRIDE+RX_IDX_B0B] = UNITY_COEF;
            r[c*RX_CH_STRIDE+RX_IDX_NCYC] = 16'(DEF_NCYC);
        end
        r[RX_IDX_MIN] = DEF_MIN1;
        r[RX_IDX_MAX] = DEF_MAX1;
        r[RX_CH_STRIDE+RX_IDX_MIN] = DEF_MIN2;
        r[RX_CH_STRIDE+RX_IDX_MAX] = DEF_MAX2;
        return r;
    endfunction
endpackage

// file: src/tpl_xfer_if.sv
// Purpose: Word crossing from the link domain to the core domain
// Assumes: Word is held stable while the request toggle is unanswered
// Notes:   Toggle handshake, one word in flight
`timescale 1ns/1ns
interface tpl_xfer_if;
    logic req_tgl;
    logic ack_tgl;
    logic [15:0] word;
    modport link (output req_tgl, output word, input ack_tgl);
    modport core (input req_tgl, input word, output ack_tgl);
endinterface

// file: src/tpl_link_port.sv
// Purpose: Link-side capture of writes to the program port
// Assumes: Bus strobe, address and data are on link_clk
// Notes:   One pending word; further writes are dropped until acked
`timescale 1ns/1ns
module tpl_link_port
    import tpl_pkg::*;
(
    input wire logic link_clk, // Link clock
    input wire logic link_rst, // Link reset, sync, high
    input wire logic bus_wr_en, // Write strobe
    input wire logic [7:0] bus_addr, // Register address
    input wire logic [15:0] bus_wdata, // Write data
    output logic link_prog_flag, // Ready flag as seen by the host
    tpl_xfer_if.link xf // Crossing to the core
);
    typedef struct packed {
        logic pending;
        logic req_tgl;
        logic [15:0] word;
        logic [2:0] ack_sync;
        logic ack_seen;
    } tpl_link_s;

    tpl_link_s q;
    tpl_link_s d;
    logic hit;
    logic ack_new;

    // ------------------------------------------------------------
    // Capture and handshake
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.ack_sync = {q.ack_sync[1:0], xf.ack_tgl};
        hit = bus_wr_en && (bus_addr == PROG_ADDR);
        ack_new = (q.ack_sync[1] == q.ack_sync[2]) && (q.ack_sync[2] != q.ack_seen);
        if (ack_new) begin
            d.ack_seen = q.ack_sync[2];
            d.pending = 1'b0;
        end
        // Host writing while busy breaks the contract; drop, keep word stable
        if (hit && !q.pending) begin
            d.word = bus_wdata;
            d.req_tgl = ~q.req_tgl;
            d.pending = 1'b1;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Flag and crossing outputs come straight from state
    assign link_prog_flag = ~q.pending;
    assign xf.req_tgl = q.req_tgl;
    assign xf.word = q.word;

    property p_link_clear;
        @(posedge link_clk) disable iff (link_rst)
        (hit && !q.pending) |=> (!link_prog_flag && xf.word == $past(bus_wdata));
    endproperty
    a_link_clear: assert property (p_link_clear) else $error("flag kept on write");

    property p_link_hold;
        @(posedge link_clk) disable iff (link_rst)
        (q.pending && !ack_new) |=> ($stable(xf.word) && $stable(xf.req_tgl));
    endproperty
    a_link_hold: assert property (p_link_hold) else $error("word moved in flight");
endmodule // tpl_link_port

// file: src/tpl_loader.sv
// Purpose: Tone program loader, tone tables and tone decision logic
// Assumes: Powersave, mode and detector inputs are on core_clk
// Notes:   Writes arrive on link_clk and cross by toggle handshake
`timescale 1ns/1ns
module tpl_loader
    import tpl_pkg::*;
#(
    parameter int PROC_LIMIT = PROC_LIMIT_CYCLES
) (
    input wire logic core_clk, // Core clock, 100 MHz
    input wire logic sys_rst, // Sync reset, high
    input wire logic ce, // Clock enable for core state
    input wire logic powersave, // Powersave level
    input wire logic link_clk, // Host link clock
    input wire logic link_rst, // Link reset, sync, high
    input wire logic bus_wr_en, // Link write strobe
    input wire logic [7:0] bus_addr, // Link address
    input wire logic [15:0] bus_wdata, // Link write data
    output logic link_prog_flag, // Ready flag, link domain
    input wire logic [15:0] gen_ctrl, // General control bits
    input wire logic tone_mode, // Programmed tone detect mode
    input wire logic [1:0] lvl_above_on, // Level above on threshold
    input wire logic [1:0] lvl_below_off, // Level below off threshold
    input wire logic [1:0] meas_valid, // Cycle timing done
    input wire logic [1:0][15:0] meas_time, // Timer counts for N cycles
    output tpl_pkg::tpl_tx_t tx_table, // Transmit pair table
    output logic [3:0] tx_single, // Pair is single tone
    output tpl_pkg::tpl_rx_t rx_active, // Receive values in use
    output logic prog_flag, // Ready flag, core domain
    output logic [15:0] status_bits, // Status bits of this block
    output logic prog_irq_event // Masked ready rise, pulse
);
    typedef struct packed {
        tpl_seq_e seq;
        logic [4:0] cnt;
        logic ready;
        logic busy;
        logic [2:0] req_sync;
        logic req_seen;
        logic ack_tgl;
        logic [15:0] word;
        logic mode_prev;
        logic [1:0] lvl_on;
        logic [1:0] per_ok;
        logic [3:0] single;
        logic [15:0] status;
        logic irq_ev;
        logic [15:0] wait_cnt;
        tpl_tx_t tx;
        tpl_rx_t rx_shadow;
        tpl_rx_t rx_act;
    } tpl_core_s;

    tpl_core_s q;
    tpl_core_s d;
    logic new_word;

    tpl_xfer_if xf_i ();

    tpl_link_port u_link (
        .link_clk(link_clk),
        .link_rst(link_rst),
        .bus_wr_en(bus_wr_en),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .link_prog_flag(link_prog_flag),
        .xf(xf_i.link)
    );

    // Period window test, shared by both channels
    function automatic logic in_window(input logic [15:0] t, input logic [15:0] lo,
                                       input logic [15:0] hi);
        return (t >= lo) && (t <= hi);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.irq_ev = 1'b0;
        d.req_sync = {q.req_sync[1:0], xf_i.req_tgl};
        // Only the settled second and third stages are compared
        new_word = (q.req_sync[1] == q.req_sync[2]) && (q.req_sync[2] != q.req_seen);
        if (q.busy) begin
            if (q.word == HDR_TX) begin
                d.seq = SEQ_TX;
                d.cnt = '0;
            end else if (q.word == HDR_RX) begin
                d.seq = SEQ_RX;
                d.cnt = '0;
            end else begin
                unique case (q.seq)
                    SEQ_IDLE: begin
                        d.seq = SEQ_IDLE;
                    end
                    SEQ_TX: begin
                        if (q.word <= TX_DATA_MAX) begin
                            // Even slots hold frequencies; cap at the top tone
                            if (!q.cnt[0] && q.word > TX_FREQ_MAX) begin
                                d.tx[q.cnt[3:0]] = TX_FREQ_MAX;
                            end else begin
                                d.tx[q.cnt[3:0]] = q.word;
                            end
                            d.cnt = q.cnt + 5'd1;
                            if (q.cnt == 5'(TX_WORDS - 1)) begin
                                d.seq = SEQ_IDLE;
                            end
                        end
                    end
                    SEQ_RX: begin
                        if (q.word <= RX_DATA_MAX) begin
                            d.rx_shadow[q.cnt] = q.word;
                            d.cnt = q.cnt + 5'd1;
                            if (q.cnt == 5'(RX_WORDS - 1)) begin
                                d.seq = SEQ_IDLE;
                            end
                        end
                    end
                    default: begin
                        d.seq = SEQ_IDLE;
                    end
                endcase
            end
            d.busy = 1'b0;
            d.ready = 1'b1;
            d.ack_tgl = ~q.ack_tgl;
        end else if (new_word) begin
            d.req_seen = q.req_sync[2];
            d.word = xf_i.word;
            d.busy = 1'b1;
            d.ready = 1'b0;
        end
        // Shadow values go live only on entry, so a running detector never glitches
        d.mode_prev = tone_mode;
        if (tone_mode && !q.mode_prev) begin
            d.rx_act = q.rx_shadow;
        end
        for (int c = 0; c < 2; c++) begin
            if (lvl_above_on[c]) begin
                d.lvl_on[c] = 1'b1;
            end else if (lvl_below_off[c]) begin
                d.lvl_on[c] = 1'b0;
            end
            if (meas_valid[c]) begin
                d.per_ok[c] = in_window(meas_time[c], q.rx_act[c*RX_CH_STRIDE+RX_IDX_MIN],
                                        q.rx_act[c*RX_CH_STRIDE+RX_IDX_MAX]);
            end
        end
        // Powersave wipes programming; the handshake itself keeps running
        if (powersave) begin
            d.tx = tx_defaults();
            d.rx_shadow = rx_defaults();
            d.rx_act = rx_defaults();
            d.seq = SEQ_IDLE;
            d.cnt = '0;
            d.lvl_on = '0;
            d.per_ok = '0;
        end
        for (int p = 0; p < 4; p++) begin
            d.single[p] = (d.tx[4*p] == '0 && d.tx[4*p+1] == '0) ||
                          (d.tx[4*p+2] == '0 && d.tx[4*p+3] == '0);
        end
        d.status = '0;
        d.status[ST_PROG_BIT] = d.ready;
        d.status[ST_TONE1_BIT] = tone_mode && q.lvl_on[0] && q.per_ok[0];
        d.status[ST_TONE2_BIT] = tone_mode && q.lvl_on[1] && q.per_ok[1];
        d.status[ST_BOTH_BIT] = d.status[ST_TONE1_BIT] && d.status[ST_TONE2_BIT];
        d.irq_ev = d.ready && !q.ready && gen_ctrl[CTRL_PROG_MASK_BIT];
        // Busy time, saturating; only the limit check reads it
        if (q.ready) begin
            d.wait_cnt = '0;
        end else if (q.wait_cnt != 16'hffff) begin
            d.wait_cnt = q.wait_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= '0;
            q.ready <= 1'b1;
            q.status <= STATUS_RESET;
            q.single <= SINGLE_RESET;
            q.tx <= tx_defaults();
            q.rx_shadow <= rx_defaults();
            q.rx_act <= rx_defaults();
        end else if (ce) begin
            q <= d;
        end
    end

    // Outputs come straight from the state register
    assign xf_i.ack_tgl = q.ack_tgl;
    assign tx_table = q.tx;
    assign tx_single = q.single;
    assign rx_active = q.rx_act;
    assign prog_flag = q.ready;
    assign status_bits = q.status;
    assign prog_irq_event = q.irq_ev;

    property p_clear;
        @(posedge core_clk) disable iff (sys_rst)
        (ce && !q.busy && new_word) |=> !prog_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("ready not cleared");

    property p_back;
        @(posedge core_clk) disable iff (sys_rst)
        (ce && $fell(prog_flag)) ##1 ce |=> prog_flag;
    endproperty
    a_back: assert property (p_back) else $error("ready not restored");

    property p_limit;
        @(posedge core_clk) disable iff (sys_rst)
        q.wait_cnt < 16'(PROC_LIMIT);
    endproperty
    a_limit: assert property (p_limit) else $error("busy too long");

    property p_defaults;
        @(posedge core_clk) disable iff (sys_rst)
        (ce && powersave) |=> (tx_table == tx_defaults() && q.rx_shadow == rx_defaults());
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults missing");

    property p_header;
        @(posedge core_clk) disable iff (sys_rst)
        (ce && q.busy && !powersave && q.word == HDR_RX) |=> (q.seq == SEQ_RX && q.cnt == 5'd0);
    endproperty
    a_header: assert property (p_header) else $error("header not taken");

    property p_rx_end;
        @(posedge core_clk) disable iff (sys_rst)
        (ce && q.busy && q.seq == SEQ_RX && q.cnt == 5'd25 && q.word <= RX_DATA_MAX
         && q.word != HDR_TX) |=> (q.seq == SEQ_IDLE);
    endproperty
    a_rx_end: assert property (p_rx_end) else $error("rx sequence too long");

    property p_idle_drop;
        @(posedge core_clk) disable iff (sys_rst)
        (ce && q.busy && q.seq == SEQ_IDLE && q.word[15] == 1'b0 && !powersave)
        |=> ($stable(tx_table) && $stable(q.rx_shadow));
    endproperty
    a_idle_drop: assert property (p_idle_drop) else $error("headerless word stored");

    property p_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (ce && tone_mode && q.mode_prev && !powersave) |=> $stable(rx_active);
    endproperty
    a_hold: assert property (p_hold) else $error("rx values changed in mode");

    property p_both;
        @(posedge core_clk) disable iff (sys_rst)
        status_bits[ST_BOTH_BIT] |-> (status_bits[ST_TONE1_BIT] && status_bits[ST_TONE2_BIT]
                                      && $past(tone_mode));
    endproperty
    a_both: assert property (p_both) else $error("both flag without tones");

    property p_hyst;
        @(posedge core_clk) disable iff (sys_rst)
        (ce && q.lvl_on[0] && !lvl_below_off[0] && !powersave) |=> q.lvl_on[0];
    endproperty
    a_hyst: assert property (p_hyst) else $error("level dropped early");

    property p_irq;
        @(posedge core_clk) disable iff (sys_rst)
        (ce && $rose(prog_flag) && $past(gen_ctrl[CTRL_PROG_MASK_BIT])) |-> prog_irq_event;
    endproperty
    a_irq: assert property (p_irq) else $error("missing ready event");

    // Transmit slot writes: frequencies capped at the top tone, levels kept as sent
    property p_tx_cap;
        @(posedge core_clk) disable iff (sys_rst)
        (ce && q.busy && !powersave && q.seq == SEQ_TX && !q.cnt[0] && q.word > TX_FREQ_MAX
         && q.word <= TX_DATA_MAX) |=> (tx_table[$past(q.cnt[3:0])] == TX_FREQ_MAX);
    endproperty
    a_tx_cap: assert property (p_tx_cap) else $error("tx frequency not capped");

    property p_tx_store;
        @(posedge core_clk) disable iff (sys_rst)
        (ce && q.busy && !powersave && q.seq == SEQ_TX && q.cnt[0] && q.word <= TX_DATA_MAX)
        |=> (tx_table[$past(q.cnt[3:0])] == $past(q.word));
    endproperty
    a_tx_store: assert property (p_tx_store) else $error("tx level word lost");
endmodule // tpl_loader

// file: sim/tpl_host_model.sv
// Purpose: Host model that writes program words over the link port
// Assumes: Driven on the link clock, one word per ready period
// Notes:   Bus lines show inverted data when idle, never stale values
`timescale 1ns/1ns
module tpl_host_model (
    input wire logic link_clk, // Link clock
    input wire logic link_prog_flag, // Ready flag from the device
    output logic bus_wr_en, // Write strobe
    output logic [7:0] bus_addr, // Address
    output logic [15:0] bus_wdata // Write data
);
    initial begin
        bus_wr_en = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 16'h0000;
    end

    // One write; skipping the ready wait is only for refusal scenarios
    task automatic wr(input logic [7:0] a, input logic [15:0] w, input logic wait_rdy);
        int n;
        n = 0;
        @(posedge link_clk);
        while (wait_rdy && link_prog_flag !== 1'b1 && n < 400) begin
            @(posedge link_clk);
            n++;
        end
        bus_wr_en <= 1'b1;
        bus_addr <= a;
        bus_wdata <= w;
        @(posedge link_clk);
        bus_wr_en <= 1'b0;
        bus_addr <= ~a;
        bus_wdata <= ~w; // Released bus must not look like the last word
    endtask
endmodule // tpl_host_model

// file: sim/tb.sv
// Purpose: Self-checking bench for the tone program loader
// Assumes: Host model drives the link port, bench drives the core side
// Notes:   Random words from a fixed seed, corner words mixed in
`timescale 1ns/1ns
module tb;
    import tpl_pkg::*;
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
    $display("mismatch %s exp %h got %h", nm, e, a); end end
    logic core_clk = 0, link_clk = 0, sys_rst = 1, link_rst = 1, powersave = 0, tone_mode = 0;
    logic [15:0] gen_ctrl = 16'h0010;
    logic ce = 1'b1;
    logic [1:0] lvl_on = 0, lvl_off = 0, meas_valid = 0;
    logic [1:0][15:0] meas_time = '0;
    logic bus_wr_en, link_prog_flag, prog_flag, prog_irq_event;
    logic [7:0] bus_addr;
    logic [15:0] bus_wdata, status_bits, w;
    logic [3:0] tx_single;
    tpl_tx_t tx_table, exp_tx;
    tpl_rx_t rx_active, exp_rx;
    int num_errors = 0, n_tests = 0, irq_n = 0, seq = 0, idx = 0, hz;

    always #5 core_clk = ~core_clk;
    // Link clock of 15 ns, phase unrelated to the core clock
    always begin
        #7 link_clk = ~link_clk;
        #8 link_clk = ~link_clk;
    end
    always @(posedge core_clk) if (prog_irq_event === 1'b1) irq_n++;

    // Short ready time keeps the internal check meaningful
    tpl_loader #(.PROC_LIMIT(64)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce),
        .powersave(powersave), .link_clk(link_clk), .link_rst(link_rst),
        .bus_wr_en(bus_wr_en), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .link_prog_flag(link_prog_flag), .gen_ctrl(gen_ctrl), .tone_mode(tone_mode),
        .lvl_above_on(lvl_on), .lvl_below_off(lvl_off), .meas_valid(meas_valid),
        .meas_time(meas_time), .tx_table(tx_table), .tx_single(tx_single),
        .rx_active(rx_active), .prog_flag(prog_flag), .status_bits(status_bits),
        .prog_irq_event(prog_irq_event));
    tpl_host_model i_host (.link_clk(link_clk), .link_prog_flag(link_prog_flag),
        .bus_wr_en(bus_wr_en), .bus_addr(bus_addr), .bus_wdata(bus_wdata));

    // ------------------------------------------------------------
    // Expected tables
    // ------------------------------------------------------------
    function automatic tpl_tx_t tx_def();
        tpl_tx_t t;
        t = '0;
        t[12] = DEF_TX_F1;
        t[13] = DEF_LEVEL;
        t[14] = DEF_TX_F2;
        t[15] = DEF_LEVEL;
        return t;
    endfunction
    function automatic tpl_rx_t rx_def();
        tpl_rx_t r;
        r = '0;
        r[2] = UNITY_COEF;
        r[7] = UNITY_COEF;
        r[15] = UNITY_COEF;
        r[20] = UNITY_COEF;
        r[10] = 16'(DEF_NCYC);
        r[23] = 16'(DEF_NCYC);
        r[11] = DEF_MIN1;
        r[12] = DEF_MAX1;
        r[24] = DEF_MIN2;
        r[25] = DEF_MAX2;
        return r;
    endfunction
    function automatic logic [3:0] sgl(input tpl_tx_t t);
        logic [3:0] s;
        for (int p = 0; p < 4; p++) begin
            s[p] = (t[4*p] == 0 && t[4*p+1] == 0) || (t[4*p+2] == 0 && t[4*p+3] == 0);
        end
        return s;
    endfunction

    // Send a word and track where the device should store it
    task automatic send(input logic [15:0] v);
        i_host.wr(PROG_ADDR, v, 1'b1);
        @(posedge link_clk);
        #1;
        `CHK("busy", 1'b0, link_prog_flag)
        if (v == HDR_TX || v == HDR_RX) begin
            seq = (v == HDR_TX) ? 1 : 2;
            idx = 0;
        end else if (seq == 1 && idx < TX_WORDS && v <= TX_DATA_MAX) begin
            exp_tx[idx] = (idx % 2 == 0 && v > TX_FREQ_MAX) ? TX_FREQ_MAX : v;
            idx++;
        end else if (seq == 2 && idx < RX_WORDS && v <= RX_DATA_MAX) begin
            exp_rx[idx] = v;
            idx++;
        end
    endtask
    task automatic settle();
        int n;
        n = 0;
        while (link_prog_flag !== 1'b1 && n < 100) begin
            @(posedge link_clk);
            n++;
        end
        `CHK("ready", 1'b1, link_prog_flag)
        repeat (3) @(posedge core_clk);
        `CHK("prog", 1'b1, prog_flag)
    endtask
    task automatic check_tx();
        settle();
        `CHK("tx", exp_tx, tx_table)
        `CHK("single", sgl(exp_tx), tx_single)
    endtask
    task automatic meas(input logic [15:0] t0, t1, e);
        @(posedge core_clk);
        meas_time <= {t1, t0};
        meas_valid <= 2'b11;
        @(posedge core_clk);
        meas_valid <= 2'b00;
        meas_time <= ~{t1, t0};
        repeat (4) @(posedge core_clk);
        `CHK("status", e, status_bits)
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #400000;
        num_errors++;
        stop_test();
    end

    initial begin
        w = $urandom(32'hc2599028);
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        link_rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        exp_tx = tx_def();
        exp_rx = rx_def();
        `CHK("status", STATUS_RESET, status_bits)
        `CHK("rx", exp_rx, rx_active)
        send(16'h0123);
        check_tx();
        // Full transmit load with a single-tone pair, a capped word and rejects
        send(HDR_TX);
        for (int i = 0; i < TX_WORDS; i++) begin
            hz = $urandom_range(3400);
            w = (i % 2 == 0) ? 16'(hz * FREQ_X1000 / 1000) : 16'($urandom_range(14209));
            if (i == 2 || i == 3) w = 16'h0000;
            if (i == 4) w = TX_DATA_MAX;
            if (i == 5) send(16'h4000);
            send(w);
            if (i == 0) i_host.wr(PROG_ADDR, HDR_RX, 1'b0);
            if (i == 1) i_host.wr(8'he9, 16'h0000, 1'b1);
        end
        send(16'h1111);
        check_tx();
        `CHK("irq", 20, irq_n)
        @(posedge core_clk);
        gen_ctrl <= 16'($urandom) & ~16'h0010;
        send(HDR_TX);
        settle();
        `CHK("irq", 20, irq_n)
        // Default detector: in range, then hysteresis hold, then level off
        @(posedge core_clk);
        tone_mode <= 1'b1;
        lvl_on <= 2'b11;
        meas(16'(DEF_MIN1 + 1), 16'(DEF_MIN2 + 1), 16'h24c0);
        lvl_on <= 2'b00;
        meas(16'(DEF_MAX1 + 1), 16'(DEF_MAX2 - 1), 16'h2080);
        lvl_off <= 2'b11;
        meas(16'(DEF_MIN1 + 1), 16'(DEF_MIN2 + 1), 16'h2000);
        // Receive load while in tone mode takes effect only on re-entry
        send(HDR_RX);
        for (int i = 0; i < RX_WORDS; i++) send(16'($urandom_range(32767)));
        settle();
        `CHK("rx hold", rx_def(), rx_active)
        // A frozen core must not notice a mode pulse while its enable is low
        ce <= 1'b0;
        tone_mode <= 1'b0;
        repeat (2) @(posedge core_clk);
        tone_mode <= 1'b1;
        repeat (2) @(posedge core_clk);
        ce <= 1'b1;
        repeat (2) @(posedge core_clk);
        `CHK("ce hold", rx_def(), rx_active)
        tone_mode <= 1'b0;
        repeat (2) @(posedge core_clk);
        tone_mode <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK("rx", exp_rx, rx_active)
        powersave <= 1'b1;
        repeat (2) @(posedge core_clk);
        powersave <= 1'b0;
        tone_mode <= 1'b0;
        repeat (2) @(posedge core_clk);
        tone_mode <= 1'b1;
        exp_tx = tx_def();
        exp_rx = rx_def();
        check_tx();
        `CHK("rx", exp_rx, rx_active)
        stop_test();
    end
endmodule // tb
